//--- design/ssc_divider.sv
// ssc_divider: divides a tick stream by a ratio, output is a square-ish wave.
// Assumes ticks are one-cycle pulses on ref_clk; ratio zero stops the output.
`timescale 1ns/1ps
module ssc_divider import ssc_pkg::*; #(
  parameter int W = 16
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset, high
  ssc_div_if.div dv // tick in, ratio in, divided wave out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } ssc_div_st_t;
  ssc_div_st_t st_reg;
  ssc_div_st_t st_next;
  // high for the first half of each ratio-long period
  always_comb
  begin
    st_next = st_reg;
    if (dv.ratio == '0)
    begin
      st_next.cnt = '0;
      st_next.out = 1'b0;
    end
    else if (dv.tick)
    begin
      if (st_reg.cnt >= dv.ratio - W'(1))
        st_next.cnt = '0;
      else
        st_next.cnt = st_reg.cnt + W'(1);
      st_next.out = (st_next.cnt < (dv.ratio >> 1)) || (dv.ratio == W'(1));
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign dv.div_out = st_reg.out;
endmodule

//--- design/ssc_sync.sv
// ssc_sync: two-flip-flop synchroniser for asynchronous pin levels.
// Assumes the pin is a level; only the second stage is visible outside.
`timescale 1ns/1ps
module ssc_sync import ssc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [W-1:0] async_in, // pin levels
  output logic [W-1:0] sync_out // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssc_sync_st_t;
  ssc_sync_st_t st_reg;
  ssc_sync_st_t st_next;
  // first stage feeds only the second
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign sync_out = st_reg.s2;
endmodule

//--- design/ssc_sysctl.sv
// ssc_sysctl: system-control word decode, commutation stepping and auxiliary clock mux.
// Assumes word_load pulses one cycle on ref_clk with the whole shifted-in 16-bit word;
// hall, aux input, zero-cross and motor clock arrive asynchronously from pins.
// Contract
// - power enable low puts everything but monitor and serial register to sleep; centre_tap_drive still follows the unipolar bit.
// - gain select low gives sense gain one, high gives five.
// - brake turns high-side inverters on and low-side drivers off.
// - voice-coil enable low drives amplifier outputs low, bias stays on.
// - current mode high lets DAC drive spindle amplifiers, else charge pump.
// - in start mode each rising commutate bit advances inverter one step.
// - unipolar low drives bipolar; high pulls centre tap low, high-sides off.
// - source 0 commutates from halls; source 1 uses back-EMF, ignores halls.
// - back-EMF mode takes initial inverter state from halls; halls default low.
// - spindle enable 0 floats phases but keeps power; charge pump unaffected.
// - start 0: phase advance is zero-cross; feedback by option LSB.
// - start 0: aux output zero-cross for option MSB 0, once-around for 1.
// - start 1: phase advance is start clock; options pick aux and feedback.
// - start clock is aux input ORed with the commutate bit.
// - once-around divides feedback by 12 for 8 poles, 18 for 12.
// - test 0 reference is motor clock over N; test 1 over 16N.
// - start bit 1, options bits 9 and 10, commutate bit 4.
// - control bits change only on a complete word addressed to this port.
// - control word layout of enable, mode, source and power bits.
// - pole bit of speed port 0 is 8 poles, 1 is 12.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_sysctl import ssc_pkg::*; #(
  parameter int REFN_W = `SSC_REFN_W
) (
  input wire logic ref_clk, // system clock, 250 MHz
  input wire logic rst, // synchronous reset, high
  input wire logic word_load, // one-cycle pulse, full word shifted in
  input wire logic [15:0] word_in, // shifted-in word incl. port and id
  input wire logic hall_in_u, // hall sensor u, async
  input wire logic hall_in_v, // hall sensor v, async
  input wire logic hall_in_w, // hall sensor w, async
  input wire logic aux_input_pin, // auxiliary input, async
  input wire logic zero_cross_clk, // back-emf zero crossing, async
  input wire logic motor_ref_clk, // speed reference clock, async
  output logic awake, // bias and logic enabled
  output logic emf_gain_sel, // sense gain five when high
  output logic high_side_on, // high-side inverters forced on
  output logic low_side_off, // low-side drivers forced off
  output logic voice_coil_out_en, // vcm amplifier drive enabled
  output logic voice_coil_bias, // vcm bias kept applied
  output logic dac_drives_spindle, // dac drives spindle amplifiers
  output logic charge_pump_path, // charge pump drives spindle amplifiers
  output logic centre_tap_drive, // centre tap drive level
  output logic high_side_en, // internal high-side drivers enabled
  output logic phase_out_en_n, // phase outputs driven when low
  output logic [2:0] inverter_step, // commutation state, 3-bit hall code or binary step 0 to 5
  output logic phase_advance_clk, // selected phase-advance clock
  output logic speed_fb_clk, // selected speed feedback clock
  output logic aux_output_pin // auxiliary output mux
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic pole12;
    logic [REFN_W-1:0] refn;
    ssc_step_t step;
    logic step_init;
    logic sck_d;
    logic hall_src_d;
    logic [3:0] pre16;
    logic mclk_d;
    logic fb_d;
    logic pa;
    logic fb;
    logic aux;
  } ssc_st_t;
  ssc_st_t st_reg;
  ssc_st_t st_next;
  logic [2:0] hall_s;
  logic aux_s;
  logic zc_s;
  logic mclk_s;
  logic sck;
  logic hall_edge;
  logic once_around;
  logic ref_out;
  ssc_mode_t mode;
  ssc_step_t hall_step;
  ssc_div_if #(.W(5)) fspn_if ();
  ssc_div_if #(.W(REFN_W + 4)) fref_if ();

  // every pin is a level from outside, so two flops first
  ssc_sync #(.W(6)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({hall_in_u, hall_in_v, hall_in_w, aux_input_pin, zero_cross_clk,
      motor_ref_clk}),
    .sync_out({hall_s, aux_s, zc_s, mclk_s})
  );

  // once-around divider on feedback clock rising edges
  assign fspn_if.tick = st_reg.fb & ~st_reg.fb_d;
  assign fspn_if.ratio = st_reg.pole12 ? `SSC_DIV_12POLE : `SSC_DIV_8POLE;
  ssc_divider #(.W(5)) u_fspn (
    .ref_clk(ref_clk),
    .rst(rst),
    .dv(fspn_if.div)
  );
  assign once_around = fspn_if.div_out;

  // reference divider: test 1 inserts a fixed divide by 16 ahead of N
  assign fref_if.tick = (mclk_s & ~st_reg.mclk_d) &
    ((mode != SSC_TEST1) || (st_reg.pre16 == 4'hF));
  assign fref_if.ratio = (REFN_W + 4)'(st_reg.refn);
  ssc_divider #(.W(REFN_W + 4)) u_fref (
    .ref_clk(ref_clk),
    .rst(rst),
    .dv(fref_if.div)
  );
  assign ref_out = fref_if.div_out;

  // start clock and mode decode from start and option bits
  assign sck = aux_s | st_reg.ctrl[`SSC_BIT_COMMUTATE];
  always_comb
  begin
    unique case ({st_reg.ctrl[`SSC_BIT_START], st_reg.ctrl[`SSC_BIT_OPT_MSB],
      st_reg.ctrl[`SSC_BIT_OPT_LSB]})
      3'h0: mode = SSC_RUN0;
      3'h1: mode = SSC_RUN1;
      3'h2: mode = SSC_RUN2;
      3'h3: mode = SSC_RUN3;
      3'h4: mode = SSC_TEST0;
      3'h5: mode = SSC_TEST1;
      3'h6: mode = SSC_TEST2;
      3'h7: mode = SSC_STARTM;
      default: mode = SSC_RUN0;
    endcase
  end

  // hall code as a step value; floating halls read zero after pull-down
  assign hall_step = hall_s;
  assign hall_edge = (st_reg.hall_src_d == 1'b0) && (hall_s != st_reg.step);

  // next-state: word load, dividers, stepping, multiplexers
  always_comb
  begin
    st_next = st_reg;
    st_next.mclk_d = mclk_s;
    st_next.fb_d = st_reg.fb;
    st_next.sck_d = sck;
    st_next.hall_src_d = st_reg.ctrl[`SSC_BIT_SERIAL_COMMUTATE_SRC];
    // only a whole word for this device and port moves the controls
    if (word_load && word_in[`SSC_ID_HI:`SSC_ID_LO] == `SSC_ID_SELECTED)
    begin
      if (word_in[`SSC_PT_HI:`SSC_PT_LO] == `SSC_PORT_SYSCTL)
        st_next.ctrl = word_in;
      else if (word_in[`SSC_PT_HI:`SSC_PT_LO] == `SSC_PORT_SPEED)
      begin
        st_next.pole12 = word_in[`SSC_BIT_POLE];
        st_next.refn = word_in[`SSC_REF_MSB:`SSC_REF_LSB];
      end
    end
    if (mclk_s & ~st_reg.mclk_d)
      st_next.pre16 = st_reg.pre16 + 4'h1;
    // asleep: stepping logic holds still, serial load above still works
    if (st_reg.ctrl[`SSC_BIT_AWAKE])
    begin
      // clear first, so a reload in the same cycle wins
      if (hall_edge)
        st_next.step_init = 1'b0;
      if (!st_reg.ctrl[`SSC_BIT_SERIAL_COMMUTATE_SRC])
        st_next.step = hall_step;
      else if (!st_reg.step_init)
      begin
        st_next.step = hall_step;
        st_next.step_init = 1'b1;
      end
      else if (mode == SSC_STARTM && sck && !st_reg.sck_d)
        st_next.step = (st_reg.step == 3'h5) ? 3'h0 : st_reg.step + 3'h1;
    end
    // multiplexers per the mode table
    unique case (mode)
      SSC_RUN0:
      begin
        st_next.pa = zc_s;
        st_next.fb = st_reg.step[0];
        st_next.aux = zc_s;
      end
      SSC_RUN1:
      begin
        st_next.pa = zc_s;
        st_next.fb = aux_s;
        st_next.aux = zc_s;
      end
      SSC_RUN2:
      begin
        st_next.pa = zc_s;
        st_next.fb = st_reg.step[0];
        st_next.aux = once_around;
      end
      SSC_RUN3:
      begin
        st_next.pa = zc_s;
        st_next.fb = aux_s;
        st_next.aux = once_around;
      end
      SSC_TEST0, SSC_TEST1:
      begin
        st_next.pa = sck;
        st_next.fb = aux_s;
        st_next.aux = ref_out;
      end
      SSC_TEST2:
      begin
        st_next.pa = sck;
        st_next.fb = aux_s;
        st_next.aux = once_around;
      end
      SSC_STARTM:
      begin
        st_next.pa = sck;
        st_next.fb = st_reg.step[0];
        st_next.aux = zc_s;
      end
    endcase
    if (!st_reg.ctrl[`SSC_BIT_AWAKE])
    begin
      st_next.pa = 1'b0;
      st_next.fb = 1'b0;
      st_next.aux = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.ctrl <= `SSC_CTRL_RESET;
    end
    else
      st_reg <= st_next;
  end

  // static controls decoded from the held word, all but centre_tap_drive gated by awake
  assign awake = st_reg.ctrl[`SSC_BIT_AWAKE];
  assign emf_gain_sel = awake & st_reg.ctrl[`SSC_BIT_GAIN];
  assign high_side_on = awake & st_reg.ctrl[`SSC_BIT_BRAKE];
  assign low_side_off = ~awake | st_reg.ctrl[`SSC_BIT_BRAKE];
  assign voice_coil_out_en = awake & st_reg.ctrl[`SSC_BIT_VCM_EN];
  assign voice_coil_bias = awake;
  assign dac_drives_spindle = awake & st_reg.ctrl[`SSC_BIT_CUR_SRC];
  assign charge_pump_path = awake & ~st_reg.ctrl[`SSC_BIT_CUR_SRC];
  assign centre_tap_drive = ~st_reg.ctrl[`SSC_BIT_UNIPOLAR];
  assign high_side_en = awake & ~st_reg.ctrl[`SSC_BIT_UNIPOLAR];
  assign phase_out_en_n = ~(awake & st_reg.ctrl[`SSC_BIT_SPN_EN]);
  assign inverter_step = st_reg.step;
  assign phase_advance_clk = st_reg.pa;
  assign speed_fb_clk = st_reg.fb;
  assign aux_output_pin = st_reg.aux;
endmodule

//--- pkg/ssc_consts.svh
// ssc_consts.svh: bit positions, codes and divide figures of the system-control word.
// Included by design files only; it defines nothing but macros.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
`define SSC_WORD_W 16
`define SSC_BIT_SPN_EN 0
`define SSC_BIT_START 1
`define SSC_BIT_SERIAL_COMMUTATE_SRC 2
`define SSC_BIT_UNIPOLAR 3
`define SSC_BIT_COMMUTATE 4
`define SSC_BIT_CUR_SRC 5
`define SSC_BIT_VCM_EN 6
`define SSC_BIT_BRAKE 7
`define SSC_BIT_GAIN 8
`define SSC_BIT_OPT_LSB 9
`define SSC_BIT_OPT_MSB 10
`define SSC_BIT_AWAKE 11
`define SSC_BIT_POLE 11
`define SSC_PT_LO 12
`define SSC_PT_HI 13
`define SSC_ID_LO 14
`define SSC_ID_HI 15
`define SSC_PORT_SPEED 2'h2
`define SSC_PORT_SYSCTL 2'h3
`define SSC_ID_SELECTED 2'h0
`define SSC_REFN_W 11
`define SSC_REF_LSB 0
`define SSC_REF_MSB 10
`define SSC_DIV_8POLE 5'h0C
`define SSC_DIV_12POLE 5'h12
`define SSC_TEST1_MULT 16
`define SSC_CTRL_RESET 16'h0000
`endif

//--- pkg/ssc_div_if.sv
// ssc_div_if: carries a clock-enable pulse into a divider and its toggling output back.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface ssc_div_if #(parameter int W = 16);
  logic tick;
  logic [W-1:0] ratio;
  logic div_out;
  modport src (output tick, output ratio, input div_out);
  modport div (input tick, input ratio, output div_out);
endinterface

//--- pkg/ssc_pkg.sv
// ssc_pkg: types shared by the spindle system-control design.
// Assumes ssc_consts.svh is available on the include path.
package ssc_pkg;
  // auxiliary mux modes, start bit and two option bits
  typedef enum logic [7:0] {
    SSC_RUN0 = 8'h01,
    SSC_RUN1 = 8'h02,
    SSC_RUN2 = 8'h04,
    SSC_RUN3 = 8'h08,
    SSC_TEST0 = 8'h10,
    SSC_TEST1 = 8'h20,
    SSC_TEST2 = 8'h40,
    SSC_STARTM = 8'h80
  } ssc_mode_t;
  // hall state of the inverter, six legal steps
  typedef logic [2:0] ssc_step_t;
endpackage

//--- tb/ssc_pins_model.sv
// ssc_pins_model: hall sensors, aux pin and motor clocks beside the spindle.
// Free-running, unrelated in phase to ref_clk.
`timescale 1ns/1ps
module ssc_pins_model (
  input wire logic aux_run, // aux pin toggles when high
  output logic hall_in_u, // hall levels
  output logic hall_in_v, // hall levels
  output logic hall_in_w, // hall levels
  output logic aux_input_pin, // aux level
  output logic zero_cross_clk, // zero crossing
  output logic motor_ref_clk // reference clock
);
  // fixed rotor position; slow edges so sync stages see them
  assign {hall_in_u, hall_in_v, hall_in_w} = 3'h5;
  initial zero_cross_clk = 1'b0;
  initial motor_ref_clk = 1'b0;
  initial aux_input_pin = 1'b0;
  always #97 zero_cross_clk = !zero_cross_clk;
  always #11 motor_ref_clk = !motor_ref_clk;
  always #61 aux_input_pin = aux_run ? !aux_input_pin : 1'b0;
endmodule

//--- tb/ssc_props.sv
// ssc_props: port-level checks on the system-control decode and clock mux.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ssc_props (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic word_load, // word strobe
  input wire logic [15:0] word_in, // word
  input wire logic aux_input_pin, // aux pin
  input wire logic zero_cross_clk, // zero cross
  input wire logic awake, // awake
  input wire logic emf_gain_sel, // gain
  input wire logic high_side_on, // brake high
  input wire logic low_side_off, // brake low
  input wire logic voice_coil_out_en, // vcm on
  input wire logic voice_coil_bias, // vcm bias
  input wire logic dac_drives_spindle, // dac path
  input wire logic charge_pump_path, // pump path
  input wire logic centre_tap_drive, // centre tap
  input wire logic high_side_en, // high sides
  input wire logic phase_out_en_n, // phases
  input wire logic phase_advance_clk, // phase_advance_clk
  input wire logic speed_fb_clk, // feedback
  input wire logic aux_output_pin // aux out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // mirror of the accepted word, so mux checks know the mode
  logic [15:0] c;
  always_ff @(posedge ref_clk)
    if (rst)
      c <= 16'h0000;
    else if (word_load && word_in[15:12] == 4'h3)
      c <= word_in;
  wire run = c[11] && !c[1];
  wire stm = c[11] && c[1] && c[10] && c[9];
  // pins cross two sync stages and a mux register
  property p_fol(logic e, logic s, logic d);
    (e && $stable(s))[*4] |-> d == s;
  endproperty
  a_sleep_safe: assert property (!awake |-> low_side_off && !high_side_on && phase_out_en_n)
    else $error("sleep outputs wrong");
  a_gain_sel: assert property (emf_gain_sel == (c[11] && c[8]))
    else $error("gain select wrong");
  a_brake_pair: assert property (high_side_on |-> low_side_off && awake)
    else $error("brake pair wrong");
  a_vcm_bias: assert property (voice_coil_out_en |-> voice_coil_bias)
    else $error("vcm bias dropped");
  a_amp_source: assert property (awake |-> dac_drives_spindle != charge_pump_path)
    else $error("amp source wrong");
  a_unipolar_hs: assert property (high_side_en |-> centre_tap_drive && awake)
    else $error("unipolar drive wrong");
  a_phase_float: assert property (phase_out_en_n == !(c[0] && c[11]))
    else $error("phase enable wrong");
  a_word_take: assert property (word_load && word_in[15:12] == 4'h3 |=>
    awake == $past(word_in[11]) && voice_coil_out_en == $past(word_in[11] && word_in[6]))
    else $error("word not taken");
  a_word_hold: assert property (!(word_load && word_in[15:12] == 4'h3) |=>
    $stable(awake) && $stable(centre_tap_drive))
    else $error("control moved");
  a_phase_advance_clk_run: assert property (p_fol(run, zero_cross_clk, phase_advance_clk))
    else $error("phase_advance_clk not zero cross");
  a_aux_zc: assert property (p_fol(run && !c[10], zero_cross_clk, aux_output_pin))
    else $error("aux out not zero cross");
  a_fb_aux: assert property (p_fol(run && c[9], aux_input_pin, speed_fb_clk))
    else $error("feedback not aux");
  a_start_clk: assert property (p_fol(stm && !c[4], aux_input_pin, phase_advance_clk))
    else $error("start clock wrong");
  c_run_aux: cover property (run && c[9]);
  c_start: cover property (stm && c[4]);
  c_sleep: cover property (awake ##1 !awake);
endmodule
bind ssc_sysctl ssc_props u_props (.*);

//--- tb/ssc_sysctl_tb.sv
// ssc_sysctl_tb: self-checking bench for the system-control decode and clock mux.
// Assumes the pin model drives halls, aux pin and motor clocks.
`timescale 1ns/1ps
module ssc_sysctl_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic word_load = 1'b0;
  logic [15:0] word_in = 16'h0000;
  logic aux_run = 1'b0;
  logic hall_in_u, hall_in_v, hall_in_w, aux_input_pin, zero_cross_clk, motor_ref_clk;
  logic awake, emf_gain_sel, high_side_on, low_side_off, voice_coil_out_en;
  logic voice_coil_bias, dac_drives_spindle, charge_pump_path, centre_tap_drive;
  logic high_side_en, phase_out_en_n, phase_advance_clk, speed_fb_clk, aux_output_pin;
  logic [2:0] inverter_step;
  logic [15:0] ctl = 16'h0000;
  logic [15:0] lf = 16'h0043;
  logic ld_d = 1'b0;
  logic [10:0] expq[$];
  logic [15:0] pbw[4] = '{16'h2003, 16'h2003, 16'h2003, 16'h2803};
  logic [15:0] mdw[4] = '{16'h3802, 16'h3A02, 16'h3C02, 16'h3C02};
  int dvs[4] = '{3, 48, 12, 18};
  int n_errors = 0;
  int check_count = 0;
  ssc_sysctl DUT (.*);
  ssc_pins_model u_pins (.*);
  always #2 ref_clk = !ref_clk;
  always @(posedge ref_clk) ld_d <= word_load;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // decoded levels the rules ask for, in output order
  function automatic logic [10:0] exp_of(input logic [15:0] c);
    return {c[11], c[11] & c[8], c[11] & c[7], !c[11] | c[7], c[11] & c[6], c[11],
      c[11] & c[5], c[11] & !c[5], !c[3], c[11] & !c[3], !(c[11] & c[0])};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // caller lowers word_load, so back-to-back words keep it high
  task automatic send(input logic [15:0] w);
    word_load <= 1'b1;
    word_in <= w;
    if (w[15:12] == 4'h3)
      ctl = w;
    expq.push_back(exp_of(ctl));
    @(posedge ref_clk);
  endtask
  // count source and aux output rises; divider phase allows one off
  task automatic ratio(input logic [15:0] pb, input logic [15:0] md, input int dv, input bit mc);
    int ni = 0;
    int no = 0;
    int e;
    logic s;
    logic pi = 1'b1;
    logic po = 1'b1;
    send(pb);
    send(md);
    word_load <= 1'b0;
    cyc(40);
    repeat (4000)
    begin
      @(negedge ref_clk);
      s = mc ? motor_ref_clk : aux_input_pin;
      ni += int'(s && !pi);
      no += int'(aux_output_pin && !po);
      pi = s;
      po = aux_output_pin;
    end
    e = ni / dv;
    chk("ratio", 16'(e), 16'((no + 1 >= e && no <= e + 1) ? e : no));
  endtask
  always @(negedge ref_clk)
    if (ld_d && expq.size() > 0)
      chk("decode", {5'h00, expq.pop_front()}, {5'h00, awake, emf_gain_sel, high_side_on,
        low_side_off, voice_coil_out_en, voice_coil_bias, dac_drives_spindle, charge_pump_path,
        centre_tap_drive, high_side_en, phase_out_en_n});
  task automatic print_verdict();
    $display("counts: checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial
  begin
    cyc(10);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      lf = nx(lf);
      send(i[0] ? {4'h3, lf[11:0]} : lf);
    end
    $display("test random words done");
    send(16'h3800);
    send(16'h3E06);
    word_load <= 1'b0;
    cyc(6);
    chk("step", 16'h0005, {13'h0, inverter_step});
    for (int k = 1; k < 4; k++)
    begin
      send(16'h3E16);
      word_load <= 1'b0;
      cyc(5);
      send(16'h3E06);
      word_load <= 1'b0;
      cyc(5);
      chk("step", 16'((5 + k) % 6), {13'h0, inverter_step});
    end
    $display("test start mode done");
    aux_run <= 1'b1;
    send(16'h3801);
    word_load <= 1'b0;
    cyc(400);
    chk("step", 16'h0005, {13'h0, inverter_step});
    send(16'h3A01);
    word_load <= 1'b0;
    cyc(400);
    send(16'h3E01);
    word_load <= 1'b0;
    cyc(400);
    send(16'h3880);
    word_load <= 1'b0;
    cyc(4);
    $display("test run modes done");
    for (int i = 0; i < 4; i++)
      ratio(pbw[i], mdw[i], dvs[i], i < 2);
    $display("test dividers done");
    print_verdict();
  end
endmodule
